// file: pkg/tbt_pkg.sv
// Constants, register map and state types for the tape block sequencer
package tbt_pkg;
  localparam int WORD_W = 12;
  localparam logic [11:0] ALL_ONES = 12'hFFF;
  localparam logic [11:0] ZERO_W = 12'h000;

  // Wishbone byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_BLOCK = 8'h04;
  localparam logic [7:0] REG_SETUP = 8'h08;
  localparam logic [7:0] REG_FIELD = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MARKWIN = 8'h14;
  localparam logic [7:0] REG_ADDR = 8'h18;

  // Operation codes in the low bits of the instruction register
  localparam logic [2:0] OP_MOVE = 3'h0;
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_READ_VFY = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_WRITE_VFY = 3'h4;
  localparam logic [2:0] OP_VERIFY = 3'h5;

  // Word bits are numbered from the right: bit n sits at [n]
  localparam int B_GROUP = 0;
  localparam int B_TAC_SEL = 2;
  localparam int B_TAC_DIR = 11;
  localparam int B_QN_SEL = 2;
  localparam int B_IN0 = 8;
  localparam int B_IN1 = 4;
  localparam int B_IN2 = 0;
  localparam int B_OUT0 = 11;
  localparam int B_OUT1 = 7;
  localparam int B_OUT2 = 3;

  // Field register layout
  localparam int F_TIF = 0;
  localparam int F_TDF = 5;
  localparam int F_GP = 10;
  localparam int F_EXT = 16;
  localparam int F_NOPAUSE = 17;
  localparam int F_MARK = 18;
  localparam int FLD_W = 19;

  // Status register layout
  localparam int S_STATE = 0;
  localparam int S_PROG = 3;
  localparam int S_BRK = 4;
  localparam int S_GEQ = 5;
  localparam int S_FWD = 6;
  localparam int S_WCYC = 7;
  localparam int S_GCNT = 8;
  localparam int S_TAC = 16;

  // Mark track codes, six lines wide
  localparam int MK_W = 6;
  localparam logic [5:0] MK_BM = 6'h15;
  localparam logic [5:0] MK_DM = 6'h0D;
  localparam logic [5:0] MK_FM = 6'h2B;
  localparam logic [5:0] MK_CM = 6'h33;

  // Line counter values
  localparam logic [1:0] LC_SET = 2'h3;
  localparam logic [1:0] LC_BRK = 2'h2;
  localparam logic [1:0] LC_LOAD = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SEARCH, ST_BLOCK, ST_CHECK_WORD
  } tbt_state_e;
endpackage : tbt_pkg

// file: pkg/tbt_tick_if.sv
// Tape line pulses and sampled tracks passed from timing to sequencer
`timescale 1ns/1ns
`default_nettype none
interface tbt_tick_if;
  logic [4:0] tp;
  logic [2:0] data;
  logic       mark_bit;
  logic       wave;
  logic       fmt_step;
  logic       mark_en;
  modport gen (output tp, output data, output mark_bit,
               output wave, output fmt_step, input mark_en);
  modport use_side (input tp, input data, input mark_bit,
                    input wave, input fmt_step, output mark_en);
endinterface : tbt_tick_if
`default_nettype wire

// file: verilog/tbt_timing.sv
// Tape pin synchronisers, line pulse sequencer and format clock divider
`timescale 1ns/1ns
`default_nettype none
module tbt_timing (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       timing_track_i,
  input  wire logic       mark_track_i,
  input  wire logic [2:0] data_track_i,
  input  wire logic       mark_clk_i,
  tbt_tick_if.gen         tk
);
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic       tt_prev;
    logic       mc_prev;
    logic [4:0] tp;
    logic       tc_lo;
    logic       tc_hi;
    logic       step;
  } tbt_tim_s;

  tbt_tim_s q;
  tbt_tim_s n;

  // Pulses 0 and 3 come from the timing track edges, the rest follow
  always_comb begin
    n = q;
    n.s1 = {mark_clk_i, mark_track_i, data_track_i, timing_track_i};
    n.s2 = q.s1;
    n.tt_prev = q.s2[0];
    n.mc_prev = q.s2[5];
    n.tp[0] = q.s2[0] & ~q.tt_prev;
    n.tp[1] = q.tp[0];
    n.tp[2] = q.tp[1];
    n.tp[3] = ~q.s2[0] & q.tt_prev;
    n.tp[4] = q.tp[3];
    n.step = 1'b0;
    // Two time counters halve and quarter the format clock
    if (tk.mark_en) begin
      if (q.s2[5] && !q.mc_prev) begin
        n.tc_lo = ~q.tc_lo;
        if (q.tc_lo) begin
          n.tc_hi = ~q.tc_hi;
          n.step = 1'b1;
        end
      end
    end else begin
      n.tc_lo = 1'b0;
      n.tc_hi = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tk.tp = q.tp;
  assign tk.data = q.s2[3:1];
  assign tk.mark_bit = q.s2[4];
  assign tk.wave = q.tc_lo; // Square wave at half the format clock
  assign tk.fmt_step = q.step;
endmodule : tbt_timing
`default_nettype wire

// file: verilog/tbt_top.sv
// Tape block transfer sequencer with Wishbone register slave
`timescale 1ns/1ns
`default_nettype none
module tbt_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        timing_track_i,
  input  wire logic        mark_track_i,
  input  wire logic [2:0]  data_track_i,
  input  wire logic        mark_clk_i,
  output logic             write_en_o,
  output logic      [2:0]  write_data_o,
  output logic             mark_write_o,
  output logic             timing_track_wave_o,
  output logic             tape_fwd_o,
  output logic             tape_motion_o,
  output logic             break_request_o,
  input  wire logic        brk_tp1_i,
  input  wire logic        brk_tp2_i,
  input  wire logic        brk_tp3_i,
  output logic      [11:0] mem_addr_o,
  output logic      [2:0]  mem_field_o,
  output logic      [11:0] mem_wdata_o,
  input  wire logic [11:0] mem_rdata_i,
  output logic             ac_load_o,
  output logic      [11:0] ac_data_o
);
  typedef struct packed {
    tbt_pkg::tbt_state_e st;
    logic        progress;
    logic        wcyc;
    logic        wsync;
    logic        wr;
    logic        rd_wait;
    logic        pend;
    logic        pend_cm;
    logic        fsel;
    logic        fwd;
    logic        brk;
    logic        ac_load;
    logic        geq;
    logic        ack;
    logic        mark_w;
    logic        lc_done;
    logic [11:0] read_write_shift_reg;
    logic [11:0] tb;
    logic [11:0] tape_accumulator;
    logic [11:0] tape_mem_address;
    logic [11:0] blk;
    logic [11:0] setup;
    logic [11:0] tape_instr_reg;
    logic [11:0] ac_data;
    logic [11:0] mem_addr;
    logic [11:0] mem_wdata;
    logic [2:0]  tf;
    logic [2:0]  gcnt;
    logic [2:0]  run_start;
    logic [2:0]  wdata;
    logic [tbt_pkg::FLD_W-1:0] fld;
    logic [1:0]  lc;
    logic [tbt_pkg::MK_W-1:0] win;
    logic [3:0]  mk;
    logic [3:0]  fwin;
    logic [31:0] rdat;
  } tbt_top_s;

  tbt_top_s q;
  tbt_top_s n;
  tbt_tick_if tk ();

  // Merge a bus write into a register on its byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    merge = (old & ~m) | (dat & m);
  endfunction : merge

  // Twelve-bit ones-complement add with end-around carry
  function automatic logic [11:0] oc_add(input logic [11:0] a,
                                         input logic [11:0] b);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    oc_add = s[11:0] + {11'h000, s[12]};
  endfunction : oc_add

  tbt_timing u_timing (
    .clk            (clk),
    .reset          (reset),
    .timing_track_i (timing_track_i),
    .mark_track_i   (mark_track_i),
    .data_track_i   (data_track_i),
    .mark_clk_i     (mark_clk_i),
    .tk             (tk.gen)
  );

  logic [2:0]  op;
  logic        grp;
  logic        bm, dm, fm, cm;
  logic        good;
  logic [11:0] want;
  logic [31:0] status;
  logic [5:0]  win_nx;
  logic        brk_due;

  assign op = q.tape_instr_reg[2:0];
  assign grp = q.tape_instr_reg[tbt_pkg::B_GROUP];
  assign {bm, dm, fm, cm} = q.mk;
  assign good = (q.tape_accumulator == tbt_pkg::ALL_ONES);
  assign want = q.blk + {9'h000, q.gcnt}; // Group blocks run consecutively
  assign win_nx = {q.win[tbt_pkg::MK_W-2:0], tk.mark_bit};
  assign tk.mark_en = q.fld[tbt_pkg::F_MARK];
  // One fetch per word: only the first count after a mark asks for it
  assign brk_due = !bm && !dm && !fm && !q.lc_done &&
                   2'(q.lc - 2'h1) == tbt_pkg::LC_BRK;

  always_comb begin
    status = '0;
    status[tbt_pkg::S_STATE +: 3] = q.st;
    status[tbt_pkg::S_PROG] = q.progress;
    status[tbt_pkg::S_BRK] = q.brk;
    status[tbt_pkg::S_GEQ] = q.geq;
    status[tbt_pkg::S_FWD] = q.fwd;
    status[tbt_pkg::S_WCYC] = q.wcyc;
    status[tbt_pkg::S_GCNT +: 3] = q.gcnt;
    status[tbt_pkg::S_TAC +: 12] = q.tape_accumulator;
  end

  always_comb begin
    n = q;
    n.ack = 1'b0;
    n.ac_load = 1'b0;

    // Register slave; acks one cycle after the strobe, then drops
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      n.ack = 1'b1;
      n.rdat = '0;
      unique case (wb_adr_i)
        tbt_pkg::REG_CMD: begin
          n.rdat = {20'h00000, q.tape_instr_reg};
          if (wb_we_i) begin
            n.tape_instr_reg = 12'(merge({20'h00000, q.tape_instr_reg}, wb_dat_i, wb_sel_i));
            // Starting an instruction restarts the sequencer
            n.progress = 1'b1;
            n.st = tbt_pkg::ST_SEARCH;
            n.tape_accumulator = q.blk;
            n.gcnt = 3'h0;
            n.run_start = 3'h0;
            n.brk = 1'b0;
            n.wsync = 1'b0;
            n.wr = 1'b0;
            n.rd_wait = 1'b0;
            n.pend = 1'b0;
            n.fwd = 1'b1;
            n.wcyc = (n.tape_instr_reg[2:0] == tbt_pkg::OP_WRITE) ||
                     (n.tape_instr_reg[2:0] == tbt_pkg::OP_WRITE_VFY);
          end
        end
        tbt_pkg::REG_BLOCK: begin
          n.rdat = {20'h00000, q.blk};
          if (wb_we_i) begin
            n.blk = 12'(merge({20'h00000, q.blk}, wb_dat_i, wb_sel_i));
          end
        end
        tbt_pkg::REG_SETUP: begin
          n.rdat = {20'h00000, q.setup};
          if (wb_we_i) begin
            n.setup = 12'(merge({20'h00000, q.setup}, wb_dat_i,
                                wb_sel_i));
          end
        end
        tbt_pkg::REG_FIELD: begin
          n.rdat = {13'h0000, q.fld};
          if (wb_we_i) begin
            n.fld = tbt_pkg::FLD_W'(merge({13'h0000, q.fld}, wb_dat_i,
                                          wb_sel_i));
          end
        end
        tbt_pkg::REG_STATUS: n.rdat = status;
        tbt_pkg::REG_MARKWIN: begin
          n.rdat = {28'h0000000, q.fwin};
          if (wb_we_i && wb_sel_i[0]) begin
            n.fwin = wb_dat_i[3:0];
          end
        end
        tbt_pkg::REG_ADDR: n.rdat = {17'h00000, q.tf, q.tape_mem_address};
        default: n.rdat = '0; // Unmapped reads zero, writes ignored
      endcase
    end

    // Format mode: window shifts out one mark line per wave period
    if (tk.fmt_step) begin
      n.mark_w = q.fwin[3];
      n.fwin = {q.fwin[2:0], 1'b0};
    end

    // Pulse 3: decode mark, shift data in or write a line out
    if (tk.tp[3]) begin
      n.win = win_nx;
      n.mk = {win_nx == tbt_pkg::MK_BM, win_nx == tbt_pkg::MK_DM,
              win_nx == tbt_pkg::MK_FM, win_nx == tbt_pkg::MK_CM};
      if (q.wr) begin
        // Check word is written in true form, data inverted
        n.wdata = {q.read_write_shift_reg[tbt_pkg::B_OUT0], q.read_write_shift_reg[tbt_pkg::B_OUT1],
                   q.read_write_shift_reg[tbt_pkg::B_OUT2]} ^
                  {3{q.st != tbt_pkg::ST_CHECK_WORD}};
        n.read_write_shift_reg = {q.read_write_shift_reg[10:0], 1'b0};
      end else begin
        n.read_write_shift_reg = {q.read_write_shift_reg[10:0], 1'b0};
        n.read_write_shift_reg[tbt_pkg::B_IN0] = tk.data[2];
        n.read_write_shift_reg[tbt_pkg::B_IN1] = tk.data[1];
        n.read_write_shift_reg[tbt_pkg::B_IN2] = tk.data[0];
      end
      if (q.wsync && q.wcyc) begin
        n.wr = 1'b1;
      end
    end

    // Pulse 4: buffer words, load address, pace write fetches
    if (tk.tp[4]) begin
      if (q.st == tbt_pkg::ST_SEARCH && bm) begin
        n.tape_mem_address = q.fld[tbt_pkg::F_EXT] ? q.setup :
                {(q.fsel ? q.fld[tbt_pkg::F_TDF +: 2]
                         : q.fld[tbt_pkg::F_TIF +: 2]),
                 q.fld[tbt_pkg::F_GP +: 2], 8'h00};
      end
      if (q.st == tbt_pkg::ST_BLOCK && !q.wcyc && (dm || fm || cm)) begin
        n.tb = q.read_write_shift_reg;
        n.pend = 1'b1;
        n.pend_cm = cm;
      end
      if (q.st == tbt_pkg::ST_BLOCK && q.wcyc) begin
        if (bm || dm) begin
          n.lc = tbt_pkg::LC_SET;
          n.lc_done = 1'b0;
        end else if (!q.lc_done && q.lc != tbt_pkg::LC_LOAD) begin
          n.lc = 2'(q.lc - 2'h1);
        end
        if (brk_due) begin
          n.brk = 1'b1;
        end
      end
      if (q.st == tbt_pkg::ST_CHECK_WORD && q.wcyc && cm) begin
        n.wsync = 1'b0;
        n.wr = 1'b0;
        if (op == tbt_pkg::OP_WRITE) begin
          n.wcyc = 1'b0;
          n.progress = 1'b0;
          n.st = tbt_pkg::ST_IDLE;
        end else if (grp && !q.geq) begin
          n.gcnt = 3'(q.gcnt + 3'h1);
          n.st = tbt_pkg::ST_SEARCH;
        end else begin
          n.wcyc = 1'b0;
          n.gcnt = q.run_start;
          n.st = tbt_pkg::ST_SEARCH;
        end
      end
      if (q.st == tbt_pkg::ST_CHECK_WORD && !q.wcyc && !q.rd_wait) begin
        unique case (op)
          tbt_pkg::OP_READ: begin
            if (good) begin
              n.progress = 1'b0;
              n.st = tbt_pkg::ST_IDLE;
            end else begin
              n.rd_wait = 1'b1;
            end
          end
          tbt_pkg::OP_VERIFY: begin
            n.progress = 1'b0;
            n.st = tbt_pkg::ST_IDLE;
          end
          tbt_pkg::OP_READ_VFY, tbt_pkg::OP_WRITE_VFY: begin
            if (!good) begin
              n.st = tbt_pkg::ST_SEARCH;
              if (op == tbt_pkg::OP_WRITE_VFY) begin
                n.wcyc = 1'b1;
                n.run_start = q.gcnt;
              end
            end else if (grp && !q.geq) begin
              n.gcnt = 3'(q.gcnt + 3'h1);
              n.st = tbt_pkg::ST_SEARCH;
            end else begin
              n.progress = 1'b0;
              n.st = tbt_pkg::ST_IDLE;
            end
          end
          default: begin
            n.progress = 1'b0;
            n.st = tbt_pkg::ST_IDLE;
          end
        endcase
      end
    end

    // Pulse 0: take the block number, sum words, load write words
    if (tk.tp[0]) begin
      if (q.st == tbt_pkg::ST_SEARCH && bm) begin
        n.tb = q.read_write_shift_reg;
      end
      if (q.pend) begin
        n.tape_accumulator = oc_add(q.tape_accumulator, q.tb);
        n.pend = 1'b0;
        if (op == tbt_pkg::OP_READ || op == tbt_pkg::OP_READ_VFY) begin
          if (!q.pend_cm) begin
            n.brk = 1'b1;
          end
        end
      end
      if (q.st == tbt_pkg::ST_BLOCK && q.wcyc) begin
        if (fm) begin
          n.tb = q.tape_accumulator;
          n.read_write_shift_reg = q.tape_accumulator;
        end else if (q.lc == tbt_pkg::LC_LOAD && !q.lc_done) begin
          n.tape_accumulator = oc_add(q.tape_accumulator, q.tb);
          n.read_write_shift_reg = q.tb;
          n.lc_done = 1'b1; // Load each fetched word only once
        end
      end
    end

    // Pulse 1: compare block numbers, pick field, start write sync
    if (tk.tp[1]) begin
      if (q.st == tbt_pkg::ST_SEARCH && bm) begin
        n.tape_accumulator = oc_add(q.tape_accumulator, q.tb);
        n.fsel = grp ? q.tape_accumulator[tbt_pkg::B_TAC_SEL]
                     : q.fld[tbt_pkg::F_GP + tbt_pkg::B_QN_SEL];
        if (!q.fld[tbt_pkg::F_EXT]) begin
          n.tf = n.fsel ? q.fld[tbt_pkg::F_TDF + 2 +: 3]
                        : q.fld[tbt_pkg::F_TIF + 2 +: 3];
        end
      end
      if (q.st == tbt_pkg::ST_BLOCK && cm && !q.wcyc &&
          !q.fld[tbt_pkg::F_NOPAUSE]) begin
        n.ac_load = 1'b1;
        n.ac_data = q.tape_accumulator;
      end
      if (q.st == tbt_pkg::ST_BLOCK && q.wcyc && !q.wsync) begin
        n.wsync = 1'b1;
      end
    end

    // Pulse 2: decide the search and enter the check word
    if (tk.tp[2]) begin
      if (q.st == tbt_pkg::ST_SEARCH && bm) begin
        if (op == tbt_pkg::OP_MOVE) begin
          n.progress = 1'b0;
          n.st = tbt_pkg::ST_IDLE;
          if (!q.fld[tbt_pkg::F_NOPAUSE]) begin
            n.ac_load = 1'b1;
            n.ac_data = q.tape_accumulator;
          end
        end else if (good && q.fwd) begin
          n.st = tbt_pkg::ST_BLOCK;
          n.tape_accumulator = tbt_pkg::ZERO_W;
          n.lc = tbt_pkg::LC_SET;
          n.lc_done = 1'b0;
        end else begin
          n.fwd = ~q.tape_accumulator[tbt_pkg::B_TAC_DIR];
          n.tape_accumulator = want;
        end
      end
      if (q.st == tbt_pkg::ST_BLOCK && ((cm && !q.wcyc) ||
          (fm && q.wcyc))) begin
        n.st = tbt_pkg::ST_CHECK_WORD;
      end
      if (q.rd_wait && cm) begin
        n.rd_wait = 1'b0;
        n.progress = 1'b0;
        n.st = tbt_pkg::ST_IDLE;
      end
    end

    // Break cycle run by the processor on its own pulses
    if (brk_tp1_i) begin
      n.mem_addr = q.tape_mem_address;
    end
    if (brk_tp2_i) begin
      n.tape_mem_address = 12'(q.tape_mem_address + 12'h001);
      n.brk = 1'b0;
    end
    if (brk_tp3_i) begin
      if (q.wcyc) begin
        n.tb = mem_rdata_i;
      end else begin
        n.mem_wdata = q.tb;
      end
    end
    // A fresh request in the clearing cycle must not be lost
    if ((tk.tp[0] && q.pend && !q.pend_cm &&
         (op == tbt_pkg::OP_READ || op == tbt_pkg::OP_READ_VFY)) ||
        (tk.tp[4] && q.st == tbt_pkg::ST_BLOCK && q.wcyc && brk_due)) begin
      n.brk = 1'b1;
    end

    // Entering search reloads the wanted number for this block
    if (n.st == tbt_pkg::ST_SEARCH && q.st != tbt_pkg::ST_SEARCH &&
        q.progress && n.progress) begin
      n.tape_accumulator = q.blk + {9'h000, n.gcnt};
    end
    n.geq = (n.gcnt == q.fld[tbt_pkg::F_GP +: 3]);
    if (!n.wcyc) begin
      n.wsync = 1'b0;
      n.wr = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from state flops
  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign write_en_o = q.wr;
  assign write_data_o = q.wdata;
  assign mark_write_o = q.mark_w;
  assign timing_track_wave_o = tk.wave;
  assign tape_fwd_o = q.fwd;
  assign tape_motion_o = q.progress;
  assign break_request_o = q.brk;
  assign mem_addr_o = q.mem_addr;
  assign mem_field_o = q.tf;
  assign mem_wdata_o = q.mem_wdata;
  assign ac_load_o = q.ac_load;
  assign ac_data_o = q.ac_data;
endmodule : tbt_top
`default_nettype wire

// file: tb/tbt_assertions.sv
// Bound port checker for the tape block sequencer
`timescale 1ns/1ns
`default_nettype none
module tbt_assertions (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        mark_clk_i,
  input wire logic        timing_track_wave_o,
  input wire logic        tape_motion_o,
  input wire logic        write_en_o,
  input wire logic [2:0]  write_data_o,
  input wire logic        break_request_o,
  input wire logic        brk_tp1_i,
  input wire logic        brk_tp2_i,
  input wire logic [11:0] mem_addr_o,
  input wire logic        ac_load_o
);
  // One clock domain; checks are void while reset is held
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_ACK_ONE: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack width wrong");
  AST_ADDR_HOLD: assert property (
    !brk_tp1_i |=> $stable(mem_addr_o))
    else $error("memory address moved outside pulse 1");
  AST_BRK_DROP: assert property (
    brk_tp2_i |=> !break_request_o)
    else $error("break request held after pulse 2");
  AST_BRK_MOT: assert property (
    break_request_o |-> tape_motion_o)
    else $error("break request while idle");
  AST_WR_MOT: assert property (
    write_en_o |-> tape_motion_o)
    else $error("writing while idle");
  AST_WR_HOLD: assert property (
    !write_en_o && !$past(write_en_o) |-> $stable(write_data_o))
    else $error("write line moved while writing off");
  AST_AC_PULSE: assert property (
    ac_load_o |=> !ac_load_o)
    else $error("accumulator load longer than a cycle");
  // Sync delay of the mark clock is a few cycles at most
  AST_WAVE: assert property (
    $changed(timing_track_wave_o) |->
      $past(mark_clk_i, 1) != $past(mark_clk_i, 6))
    else $error("timing wave moved without a mark clock edge");
endmodule : tbt_assertions
bind tbt_top tbt_assertions tbt_assertions_inst (.*);
`default_nettype wire

// file: tb/tbt_partner.sv
// Tape head and processor break-cycle model
`timescale 1ns/1ns
`default_nettype none
module tbt_partner (
  input  wire logic        clk,
  output logic             timing_track_i,
  output logic             mark_track_i,
  output logic      [2:0]  data_track_i,
  input  wire logic        break_request_o,
  output logic             brk_tp1_i,
  output logic             brk_tp2_i,
  output logic             brk_tp3_i,
  input  wire logic [11:0] mem_addr_o,
  input  wire logic [11:0] mem_wdata_o,
  output logic      [11:0] mem_rdata_i
);
  logic [11:0] mem [0:15];
  int          c = 0;
  int          dly = 0;
  int          nbrk = 0;

  // Quiet tape and cleared memory at time zero
  initial begin
    timing_track_i = 1'b0;
    mark_track_i = 1'b0;
    data_track_i = 3'h0;
    for (int i = 0; i < 16; i++)
      mem[i] = 12'h000;
  end

  // Break cycle after dly idle cycles, then pulses 1, 2, 3 and a store
  always @(posedge clk) begin
    if (c > dly + 3)
      c <= 0;
    else if (c > 0 || break_request_o)
      c <= c + 1;
    if (brk_tp1_i)
      nbrk <= nbrk + 1;
    if (c == dly + 4)
      mem[mem_addr_o[3:0]] <= mem_wdata_o;
  end
  assign brk_tp1_i = (c == dly + 1);
  assign brk_tp2_i = (c == dly + 2);
  assign brk_tp3_i = (c == dly + 3);
  assign mem_rdata_i = mem[mem_addr_o[3:0]];

  // One line: six cycles high, eight low, tracks steady across it
  task automatic line(input logic m, input logic [2:0] d);
    timing_track_i <= 1'b1;
    mark_track_i <= m;
    data_track_i <= d;
    repeat (6) @(posedge clk);
    timing_track_i <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : line

  // Six lines of mark code; the last four carry a word, left bits first
  task automatic frame(input logic [5:0] k, input logic [11:0] w);
    for (int i = 0; i < 6; i++)
      line(k[5-i], i < 2 ? 3'h0 : {w[13-i], w[9-i], w[5-i]});
  endtask : frame

  task automatic blk(input logic [11:0] n, a, b, ck);
    frame(tbt_pkg::MK_BM, n);
    frame(tbt_pkg::MK_DM, a);
    frame(tbt_pkg::MK_FM, b);
    frame(tbt_pkg::MK_CM, ck);
    line(1'b0, 3'h0); // Check mark acts on the pulses of the next line
  endtask : blk
endmodule : tbt_partner
`default_nettype wire

// file: tb/tb_tbt_top.sv
// Self-checking bench for the tape block sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_tbt_top;
  localparam logic [11:0] W0 = 12'h123;
  localparam logic [11:0] W1 = 12'hABC;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic        mark_clk_i = 1'b0;
  logic        wen_seen = 1'b0;
  logic [31:0] wb_dat_o, rd;
  logic        wb_ack_o, timing_track_i, mark_track_i, write_en_o;
  logic [2:0]  data_track_i, write_data_o, mem_field_o;
  logic        mark_write_o, timing_track_wave_o, tape_fwd_o;
  logic        tape_motion_o, break_request_o, ac_load_o;
  logic        brk_tp1_i, brk_tp2_i, brk_tp3_i;
  logic [11:0] mem_addr_o, mem_wdata_o, mem_rdata_i, ac_data_o, ac_seen;
  int          err_count = 0;
  int          comparisons = 0;
  int          waves = 0;

  tbt_top     tbt_top_inst (.*);
  tbt_partner tbt_partner_inst (.*);

  initial forever #20 clk = ~clk;

  // Catch one-cycle pulses and wave edges as they pass
  always @(posedge clk) begin
    if (ac_load_o === 1'b1)
      ac_seen <= ac_data_o;
    if (write_en_o === 1'b1)
      wen_seen <= 1'b1;
  end
  always @(timing_track_wave_o)
    waves++;

  task automatic results;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Ones-complement add with end-around carry
  function automatic logic [11:0] oc(input logic [11:0] a, b);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[11:0] + 12'(s[12]);
  endfunction : oc

  // Classic single cycle; the answer is awaited, never assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20)
      err_count++;
  endtask : wb

  // Start an operation, pass a wrong block, then the wanted block 5
  task automatic run(input logic [2:0] op, input logic [11:0] ck, input int nb);
    int b;
    int n;
    b = tbt_partner_inst.nbrk;
    ac_seen = 12'h000;
    wb(1'b1, tbt_pkg::REG_CMD, {29'h0, op});
    tbt_partner_inst.frame(tbt_pkg::MK_BM, ~12'h003);
    tbt_partner_inst.blk(~12'h005, W0, W1, ck);
    n = 0;
    while (tape_motion_o !== 1'b0 && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk("motion", 32'h0, 32'(tape_motion_o));
    chk("breaks", nb, tbt_partner_inst.nbrk - b);
  endtask : run

  initial begin
    int w;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    wb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, tbt_pkg::REG_BLOCK, 32'h5);
    wb(1'b0, tbt_pkg::REG_BLOCK, 32'h0);
    chk("block", 32'h5, rd);
    wb(1'b1, tbt_pkg::REG_FIELD, 32'h0);
    run(tbt_pkg::OP_READ, ~oc(W0, W1), 2);
    chk("ac read", 32'hFFF, 32'(ac_seen));
    chk("mem0", 32'(W0), 32'(tbt_partner_inst.mem[0]));
    chk("mem1", 32'(W1), 32'(tbt_partner_inst.mem[1]));
    chk("fwd", 32'h1, 32'(tape_fwd_o));
    wb(1'b0, tbt_pkg::REG_ADDR, 32'h0);
    chk("addr", 32'h2, rd);
    run(tbt_pkg::OP_VERIFY, ~oc(W0, W1), 0);
    chk("ac vfy", 32'hFFF, 32'(ac_seen));
    run(tbt_pkg::OP_VERIFY, ~oc(W0, W1) ^ 12'h001, 0);
    chk("ac bad", 32'(oc(oc(W0, W1), ~oc(W0, W1) ^ 12'h001)),
        32'(ac_seen));
    tbt_partner_inst.dly = 6;
    run(tbt_pkg::OP_WRITE, 12'h000, 2);
    chk("write on", 32'h1, 32'(wen_seen));
    tbt_partner_inst.dly = 0;
    run(tbt_pkg::OP_MOVE, 12'h000, 0);
    chk("ac move", 32'(oc(12'h005, ~12'h003)), 32'(ac_seen));
    wb(1'b1, tbt_pkg::REG_MARKWIN, 32'hA);
    wb(1'b1, tbt_pkg::REG_FIELD, 32'h40000);
    repeat (2) @(posedge clk);
    w = waves;
    repeat (8) begin
      mark_clk_i <= 1'b1;
      repeat (8) @(posedge clk);
      mark_clk_i <= 1'b0;
      repeat (8) @(posedge clk);
    end
    chk("wave", 32'h8, 32'(waves - w));
    wb(1'b0, tbt_pkg::REG_MARKWIN, 32'h0);
    chk("markwin", 32'h0, rd);
    results();
  end

  // Whole run needs about 2300 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    results();
  end
endmodule : tb_tbt_top
`default_nettype wire
